// *** tb/scsp_bus_master.sv ***
module scsp_bus_master (
    output logic      scl,
    output logic      sdaDrv,
    input  wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 100ps;
    // quarter of the 320 ns bus period, exactly two core clock periods
    localparam int Q = 80;

    // bus clock stands high and data is released between frames
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    // start and repeated start alike: data falls while clock high
    // pins move by non-blocking assignment: the steps land on core
    // clock edges, and this keeps the synchronisers free of races
    task automatic start();
        #Q sdaDrv <= 1'b1;
        #Q scl <= 1'b1;
        #Q sdaDrv <= 1'b0;
        #Q scl <= 1'b0;
    endtask
    task automatic stop();
        #Q sdaDrv <= 1'b0;
        #Q scl <= 1'b1;
        #Q sdaDrv <= 1'b1;
        #Q;
    endtask
    // data set mid low phase, sampled mid high phase
    task automatic bitx(input logic b, output logic r);
        #Q sdaDrv <= b;
        #Q scl <= 1'b1;
        #Q r = sdaLine;
        #Q scl <= 1'b0;
    endtask
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic getByte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(nack, r);
    endtask
endmodule

// *** tb/scsp_properties.sv ***
`include "scsp_regs.svh"

module scsp_properties #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic                  core_clk,
    input wire logic                  srst,
    input wire logic                  scl,
    input wire logic                  sdaIn,
    input wire logic                  sdaOut,
    input wire logic                  sdaOe,
    input wire logic                  wrValid,
    input wire logic                  wrReady,
    input wire scsp_pkg::scsp_idx_t   wrIndex,
    input wire scsp_pkg::scsp_byte_t  wrData,
    input wire scsp_pkg::scsp_byte_t  outCtrl,
    input wire scsp_pkg::scsp_byte_t  spreadSel
);
    timeunit 1ns;
    timeprecision 100ps;
    import scsp_pkg::*;

    // one domain only, so clock and reset are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
        else $error("data pin value is not low");
    AST_RST_IDLE: assert property (
        $fell(srst) |-> !sdaOe && !wrValid)
        else $error("bus or buffer busy after reset");
    AST_RST_CFG: assert property ($fell(srst) |->
        outCtrl == `SCSP_RST_CTRL && spreadSel == `SCSP_RST_SPREAD)
        else $error("config bytes wrong after reset");
    AST_HOLD_HEAD: assert property (wrValid && !wrReady |=>
        wrValid && $stable({wrIndex, wrData}))
        else $error("buffer head moved while stalled");
    AST_CTRL_COMMIT: assert property (
        wrValid && wrReady && wrIndex == 2'h1
        |=> outCtrl == $past(wrData))
        else $error("control byte not committed");
    AST_SPREAD_COMMIT: assert property (
        wrValid && wrReady && wrIndex == 2'h2
        |=> spreadSel == $past(wrData))
        else $error("spread byte not committed");
    AST_CFG_KEEP: assert property (!(wrValid && wrReady)
        |=> $stable(outCtrl) && $stable(spreadSel))
        else $error("config changed without a commit");
    AST_ID_NO_EFFECT: assert property (
        wrValid && wrReady && wrIndex == 2'h0
        |=> $stable(outCtrl) && $stable(spreadSel))
        else $error("identity write changed config");
    // the data line may only move while the bus clock is low
    AST_OE_SCL_HIGH: assert property (
        scl && $past(scl) && $past(scl, 2) |-> $stable(sdaOe))
        else $error("data line moved with bus clock high");
    AST_IDX_RANGE: assert property (wrValid |-> wrIndex != 2'h3)
        else $error("out of range index queued");

    COV_CTRL: cover property (wrValid && wrReady && wrIndex == 2'h1);
    COV_STALL: cover property (wrValid && !wrReady [*8]);
    COV_DRIVE: cover property ($rose(sdaOe));
endmodule

bind scsp_slave scsp_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .core_clk(core_clk), .srst(srst), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .wrValid(wrValid),
    .wrReady(wrReady), .wrIndex(wrIndex), .wrData(wrData),
    .outCtrl(outCtrl), .spreadSel(spreadSel));

// *** tb/testbench.sv ***
`include "scsp_regs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ID = 8'h3c; // arbitrary identity value
    localparam logic [7:0] WA = {`SCSP_SLAVE_ADDR7, 1'b0};

    logic        core_clk;
    logic        srst;
    logic        wrReady;
    logic        hold;
    logic        sdaOut;
    logic        sdaOe;
    logic        wrValid;
    logic [1:0]  wrIndex;
    logic [7:0]  wrData;
    logic [7:0]  outCtrl;
    logic [7:0]  spreadSel;
    logic        scl;
    logic        sdaDrv;
    logic        ack;
    wire logic   sdaLine;
    logic [31:0] seed = 32'h0b8c04e3;
    logic [7:0]  mdl [4];
    logic [9:0]  pend [$];
    int          errors;
    int          testsRun;

    // pulled up line: low if either party drives it
    assign sdaLine = sdaDrv & !sdaOe;

    scsp_slave #(.ID_BYTE(ID), .FIFO_DEPTH(8)) dut (
        .core_clk(core_clk), .srst(srst), .scl(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .wrValid(wrValid),
        .wrReady(wrReady), .wrIndex(wrIndex), .wrData(wrData),
        .outCtrl(outCtrl), .spreadSel(spreadSel));
    scsp_bus_master bm (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // random stall on the commit side unless the buffer is held
    always @(posedge core_clk) begin
        seed <= lfsr(seed);
        wrReady <= !hold && seed[3];
    end
    // committed entries leave in the order the model queued them
    always @(posedge core_clk)
        if (!srst && wrValid === 1'b1 && wrReady === 1'b1)
            check({wrIndex, wrData}, pend.pop_front());

    ////////////////////////////////////////
    // block command is zero, single carries the offset
    task automatic wrTxn(input logic blk, input logic [1:0] ofs,
                         input int n, input int nb, input int part);
        logic       r;
        logic       ok;
        logic [7:0] d;
        int         idx;
        bm.start();
        bm.sendByte(WA, ack);
        check({9'h0, ack}, 10'h1);
        bm.sendByte(blk ? 8'h00 : {6'h20, ofs}, ack);
        check({9'h0, ack}, 10'h1);
        if (blk) begin
            bm.sendByte(n[7:0], ack);
            check({9'h0, ack}, 10'h1);
        end
        for (int k = 0; k < nb; k++) begin
            d = seed[15:8];
            idx = blk ? k : int'(ofs);
            // taken only in range, within the count and with space
            ok = idx < 3 && (blk ? k < n : k == 0) && pend.size() < 8;
            // queued before the byte: the core may drain it long
            // before the ack bit has ended on the wire
            if (ok) begin
                pend.push_back({idx[1:0], d});
                if (idx != 0)
                    mdl[idx] = d;
            end
            bm.sendByte(d, ack);
            check({9'h0, ack}, {9'h0, ok});
        end
        for (int k = 0; k < part; k++)
            bm.bitx(1'b0, r);
        bm.stop();
    endtask
    task automatic drain();
        for (int t = 0; t < 400 && pend.size() != 0; t++)
            @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        check({9'h0, wrValid}, 10'h0);
        check({2'h0, outCtrl}, {2'h0, mdl[1]});
        check({2'h0, spreadSel}, {2'h0, mdl[2]});
    endtask
    task automatic rdTxn(input logic blk, input logic [1:0] ofs);
        logic [7:0] v;
        bm.start();
        bm.sendByte(WA, ack);
        bm.sendByte(blk ? 8'h00 : {6'h20, ofs}, ack);
        bm.start();
        bm.sendByte(WA | 8'h01, ack);
        check({9'h0, ack}, 10'h1);
        if (blk) begin
            bm.getByte(1'b0, v);
            check({2'h0, v}, {2'h0, `SCSP_NUM_BYTES});
            for (int k = 0; k < 3; k++) begin
                bm.getByte(k == 2, v);
                check({2'h0, v}, {2'h0, mdl[k]});
            end
        end else begin
            bm.getByte(1'b1, v);
            check({2'h0, v}, {2'h0, mdl[ofs]});
        end
        bm.stop();
    endtask

    ////////////////////////////////////////
    initial begin
        srst = 1'b1;
        hold = 1'b0;
        errors = 0;
        testsRun = 0;
        mdl = '{ID, `SCSP_RST_CTRL, `SCSP_RST_SPREAD, 8'h00};
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        drain();
        $display("test reset done");
        bm.start();
        bm.sendByte(8'ha4, ack);
        check({9'h0, ack}, 10'h0);
        bm.sendByte(8'h00, ack);
        check({9'h0, ack}, 10'h0);
        bm.stop();
        $display("test foreign address done");
        for (int i = 2; i >= 0; i--) begin
            wrTxn(1'b0, i[1:0], 0, 2, 0);
            drain();
        end
        for (int i = 0; i < 4; i++)
            rdTxn(1'b0, i[1:0]);
        $display("test single byte done");
        wrTxn(1'b1, 2'h0, 3, 4, 0);
        drain();
        wrTxn(1'b1, 2'h0, 3, 1, 4);
        drain();
        rdTxn(1'b1, 2'h0);
        $display("test block done");
        @(posedge core_clk) hold <= 1'b1;
        repeat (3)
            wrTxn(1'b1, 2'h0, 3, 3, 0);
        @(posedge core_clk) hold <= 1'b0;
        drain();
        $display("test buffer full done");
        summarize();
    end
    // the sequence needs well under half a millisecond
    initial begin
        #1000000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end
endmodule

// *** verilog/scsp_fifo.sv ***
module scsp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input wire logic   clk,
    input wire logic   rst,
    scsp_stream_if.snk inS,
    scsp_stream_if.src outS
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // honest flags from the fill count
    assign inS.ready  = (cnt_r != (AW+1)'(DEPTH));
    assign outS.valid = (cnt_r != '0);
    assign outS.data  = mem[rdPtr_r];
    assign push       = inS.valid & inS.ready;
    assign pop        = outS.valid & outS.ready;

    // storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inS.data;
        end
    end

    // pointers wrap explicitly so any depth works
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            cnt_r   <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// *** verilog/scsp_pkg.sv ***
package scsp_pkg;
    // bit engine states
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_RXBYTE = 5'b00010,
        ST_ACKOUT = 5'b00100,
        ST_TXBYTE = 5'b01000,
        ST_ACKIN  = 5'b10000
    } scsp_state_t;

    // meaning of the byte now on the wire
    typedef enum logic [4:0] {
        PH_ADDR  = 5'b00001,
        PH_CMD   = 5'b00010,
        PH_COUNT = 5'b00100,
        PH_DATA  = 5'b01000,
        PH_READ  = 5'b10000
    } scsp_phase_t;

    typedef logic [1:0] scsp_idx_t;
    typedef logic [7:0] scsp_byte_t;
endpackage

// *** verilog/scsp_regs.svh ***
`ifndef SCSP_REGS_SVH
`define SCSP_REGS_SVH
// Behaviour
// [R1] The port serves byte write, byte read, block write and block read.
// [R2] Block bytes move in rising index order from byte 0, MSB first.
// [R3] A stop after any whole byte keeps it; a partial byte is dropped.
// [R4] Command bit 7 low means block access, high means single-byte access.
// [R5] The master puts the offset in command bits 6..0, zero for blocks.
// [R6] Only an address byte matching the fixed slave address is answered.
// [R7] Block write is address, zero command, count, then acked data bytes.
// [R8] Block read is command, repeated start, read address, count, data.
// [R9] On block read the master acks all but the last byte, then stops.
// [R10] Single-byte access uses command bits 1..0 as the byte offset.
// [R11] A single-byte command has bit 7 set and the upper bits clear.
// [R12] Byte write takes one data byte, acks and stores it, then stop.
// [R13] Byte read returns one byte after a repeated start, master nacks.
// [R14] Bytes 0, 1 and 2 hold identity, output control and spread select.
// [R15] A foreign address is nacked and the data line stays released.

////////////////////////////////////////////////////////////////////////////
// bus address, 7 bits (d2 with the write bit appended)
`define SCSP_SLAVE_ADDR7   7'h69
// command code fields
`define SCSP_CMD_SINGLE    7
`define SCSP_CMD_OFS_HI    1
// byte map
`define SCSP_IDX_ID        2'h0
`define SCSP_IDX_CTRL      2'h1
`define SCSP_IDX_SPREAD    2'h2
`define SCSP_NUM_BYTES     8'h03
// reset values
`define SCSP_RST_CTRL      8'hf7
`define SCSP_RST_SPREAD    8'h02
// bits per byte on the wire
`define SCSP_BYTE_BITS     4'h8
`define SCSP_LAST_TX_BIT   4'h7
`endif

// *** verilog/scsp_slave.sv ***
`include "scsp_regs.svh"

module scsp_slave #(
    parameter logic [7:0] ID_BYTE    = 8'ha5, // arbitrary identity value
    parameter int         FIFO_DEPTH = 8
) (
    input  wire logic               core_clk,
    input  wire logic               srst,
    input  wire logic               scl,
    input  wire logic               sdaIn,
    output logic                    sdaOut,
    output logic                    sdaOe,
    output logic                    wrValid,
    input  wire logic               wrReady,
    output scsp_pkg::scsp_idx_t     wrIndex,
    output scsp_pkg::scsp_byte_t    wrData,
    output scsp_pkg::scsp_byte_t    outCtrl,
    output scsp_pkg::scsp_byte_t    spreadSel
);
    import scsp_pkg::*;

    logic [1:0]  sclSync_r;
    logic [1:0]  sdaSync_r;
    logic        sclD_r;
    logic        sdaD_r;
    logic        sclS;
    logic        sdaS;
    logic        sclRise;
    logic        sclFall;
    logic        startCond;
    logic        stopCond;

    scsp_state_t state_r;
    scsp_phase_t phase_r;
    logic [3:0]  bitCnt_r;
    scsp_byte_t  rxSh_r;
    scsp_byte_t  txSh_r;
    logic        blockMode_r;
    logic [7:0]  idx_r;
    scsp_byte_t  remain_r;
    logic        byteDone_r;
    logic        ackBit_r;
    scsp_byte_t  ctrl_r;
    scsp_byte_t  spread_r;

    logic        byteEnd;
    logic        ackNow;
    logic        pushReq;

    scsp_stream_if #(.W(10)) inS ();
    scsp_stream_if #(.W(10)) outS ();

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; idle bus is high so reset to one
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sclSync_r <= 2'h3;
            sdaSync_r <= 2'h3;
            sclD_r    <= 1'b1;
            sdaD_r    <= 1'b1;
        end else begin
            sclSync_r <= {sclSync_r[0], scl};
            sdaSync_r <= {sdaSync_r[0], sdaIn};
            sclD_r    <= sclSync_r[1];
            sdaD_r    <= sdaSync_r[1];
        end
    end

    // edges and bus conditions, only from the second stage onward
    assign sclS      = sclSync_r[1];
    assign sdaS      = sdaSync_r[1];
    assign sclRise   = sclS & ~sclD_r;
    assign sclFall   = ~sclS & sclD_r;
    assign startCond = sclS & sclD_r & ~sdaS & sdaD_r;
    assign stopCond  = sclS & sclD_r & sdaS & ~sdaD_r;

    ////////////////////////////////////////////////////////////////////////
    // byte map seen by reads
    // [R14] three config bytes
    function automatic scsp_byte_t cfgByte(input logic [7:0] i);
        case (i)
            {6'h0, `SCSP_IDX_ID}:     cfgByte = ID_BYTE;
            {6'h0, `SCSP_IDX_CTRL}:   cfgByte = ctrl_r;
            {6'h0, `SCSP_IDX_SPREAD}: cfgByte = spread_r;
            default:                  cfgByte = 8'h00;
        endcase
    endfunction

    assign byteEnd = (state_r == ST_RXBYTE) && sclFall
                     && (bitCnt_r == `SCSP_BYTE_BITS);

    // ack decision for the byte just received
    always_comb begin
        ackNow  = 1'b0;
        pushReq = 1'b0;
        case (phase_r)
            // [R6] [R15] address match only
            PH_ADDR:  ackNow = (rxSh_r[7:1] == `SCSP_SLAVE_ADDR7);
            PH_CMD:   ackNow = 1'b1;
            PH_COUNT: ackNow = 1'b1;
            PH_DATA: begin
                // [R12] single byte once; [R7] block up to the count
                // full buffer nacks so the master sees the stall
                ackNow  = inS.ready && (idx_r < `SCSP_NUM_BYTES)
                          && (blockMode_r ? (remain_r != 8'h00)
                                          : !byteDone_r);
                pushReq = ackNow;
            end
            default:  ackNow = 1'b0;
        endcase
    end

    // [R3] only whole, acked bytes reach the buffer
    assign inS.valid = byteEnd & pushReq;
    assign inS.data  = {idx_r[1:0], rxSh_r};

    ////////////////////////////////////////////////////////////////////////
    // bit engine and transaction context
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r     <= ST_IDLE;
            phase_r     <= PH_ADDR;
            bitCnt_r    <= 4'h0;
            rxSh_r      <= 8'h00;
            txSh_r      <= 8'h00;
            blockMode_r <= 1'b0;
            idx_r       <= 8'h00;
            remain_r    <= 8'h00;
            byteDone_r  <= 1'b0;
            ackBit_r    <= 1'b0;
        end else if (startCond) begin
            // repeated start keeps the command context
            state_r  <= ST_RXBYTE;
            phase_r  <= PH_ADDR;
            bitCnt_r <= 4'h0;
        end else if (stopCond) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_RXBYTE: begin
                    if (sclRise) begin
                        // [R2] msb arrives first
                        rxSh_r   <= {rxSh_r[6:0], sdaS};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (byteEnd) begin
                        bitCnt_r <= 4'h0;
                        // [R15] nack parks the engine until a start
                        state_r  <= ackNow ? ST_ACKOUT : ST_IDLE;
                        case (phase_r)
                            PH_ADDR: begin
                                if (rxSh_r[0]) begin
                                    phase_r <= PH_READ;
                                    if (blockMode_r) begin
                                        // [R8] count leads a block read
                                        txSh_r <= `SCSP_NUM_BYTES;
                                        idx_r  <= 8'h00;
                                    end else begin
                                        // [R13] the one addressed byte
                                        txSh_r <= cfgByte(idx_r);
                                        idx_r  <= idx_r + 8'h01;
                                    end
                                end else begin
                                    phase_r <= PH_CMD;
                                end
                            end
                            PH_CMD: begin
                                // [R4] bit 7 picks block or single
                                blockMode_r <= ~rxSh_r[`SCSP_CMD_SINGLE];
                                // [R10] offset from low two bits
                                idx_r <= {6'h0, rxSh_r[`SCSP_CMD_OFS_HI:0]};
                                byteDone_r <= 1'b0;
                                phase_r <= rxSh_r[`SCSP_CMD_SINGLE]
                                           ? PH_DATA : PH_COUNT;
                            end
                            PH_COUNT: begin
                                // [R7] count then data from byte 0
                                remain_r <= rxSh_r;
                                idx_r    <= 8'h00;
                                phase_r  <= PH_DATA;
                            end
                            PH_DATA: begin
                                if (ackNow) begin
                                    // [R2] ascending index
                                    idx_r      <= idx_r + 8'h01;
                                    remain_r   <= remain_r - 8'h01;
                                    byteDone_r <= 1'b1;
                                end
                            end
                            default: phase_r <= PH_ADDR;
                        endcase
                    end
                end
                ST_ACKOUT: begin
                    if (sclFall) begin
                        state_r <= (phase_r == PH_READ) ? ST_TXBYTE
                                                        : ST_RXBYTE;
                    end
                end
                ST_TXBYTE: begin
                    if (sclFall) begin
                        if (bitCnt_r == `SCSP_LAST_TX_BIT) begin
                            bitCnt_r <= 4'h0;
                            state_r  <= ST_ACKIN;
                        end else begin
                            txSh_r   <= {txSh_r[6:0], 1'b0};
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end
                    end
                end
                ST_ACKIN: begin
                    if (sclRise) begin
                        ackBit_r <= ~sdaS;
                    end else if (sclFall) begin
                        // [R9] master nack ends the read
                        if (ackBit_r) begin
                            txSh_r  <= cfgByte(idx_r);
                            idx_r   <= idx_r + 8'h01;
                            state_r <= ST_TXBYTE;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // open-drain data: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOe  = (state_r == ST_ACKOUT)
                    || ((state_r == ST_TXBYTE) && !txSh_r[7]);

    ////////////////////////////////////////////////////////////////////////
    // write buffer; the core drains it and may stall
    // [R1] all four transfer kinds end up here or in cfgByte
    scsp_fifo #(
        .WIDTH (10),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk  (core_clk),
        .rst  (srst),
        .inS  (inS),
        .outS (outS)
    );

    assign wrValid    = outS.valid;
    assign outS.ready = wrReady;
    assign wrIndex    = outS.data[9:8];
    assign wrData     = outS.data[7:0];

    // config bytes commit on drain; reads may lag queued writes
    // [R12] store at the addressed offset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_r   <= `SCSP_RST_CTRL;
            spread_r <= `SCSP_RST_SPREAD;
        end else if (outS.valid && wrReady) begin
            if (wrIndex == `SCSP_IDX_CTRL) begin
                ctrl_r <= wrData;
            end
            if (wrIndex == `SCSP_IDX_SPREAD) begin
                spread_r <= wrData;
            end
        end
    end

    assign outCtrl   = ctrl_r;
    assign spreadSel = spread_r;
endmodule

// *** verilog/scsp_stream_if.sv ***
interface scsp_stream_if #(
    parameter int W = 10
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
